// *** design/auirs_pkg.sv ***
// package: register map, field positions and reset values of the advanced uart status block
// How it works
// - rx dma without tx dma uses one channel
// - last byte of frame flag at fifo bottom
// - length exceeded flag blocks further rx writes
// - illegal symbol flags error, aborts, ends frame
// - bad crc sets crc error flag
// - flow control flag, cleared by status read
// - underrun on empty without frame end or terminal count; w1c
// - receiver busy or in-process status bit
// - lost frame end flag, cleared by read
// - remote pulse flag, cleared by read
// - frame end still in rx fifo flag
// - rx or status fifo timeout flag
// - legacy divisor access in advanced mode reverts legacy
// - legacy fallback clears two bits unless disabled
// - legacy set regs 2-7 mirror set 0
// - shared offsets 2 and 3 in legacy set
// - advanced set offsets 4, 6, 7; 5 reserved
// - channel swap zero rx, one tx
// - set select writable anywhere, e0 and e4
package auirs_pkg;
  localparam logic [3:0] OFS_DIV_LO    = 4'h0;
  localparam logic [3:0] OFS_DIV_HI    = 4'h1;
  localparam logic [3:0] OFS_IRQ_FIFO  = 4'h2;
  localparam logic [3:0] OFS_LINE_SET  = 4'h3;
  localparam logic [3:0] OFS_HS_CTRL   = 4'h4;
  localparam logic [3:0] OFS_LINE_STAT = 4'h5;
  localparam logic [3:0] OFS_HS_STAT   = 4'h6;
  localparam logic [3:0] OFS_USER_STAT = 4'h7;
  localparam logic [3:0] OFS_ADV_CTRL2 = 4'h4;
  localparam logic [3:0] OFS_TX_LEVEL  = 4'h6;
  localparam logic [3:0] OFS_RX_LEVEL  = 4'h7;
  localparam logic [3:0] OFS_IR_SELECT = 4'h3;
  localparam logic [7:0] SET2_CODE     = 8'he0;
  localparam logic [7:0] SET3_CODE     = 8'he4;
  localparam logic [7:0] SET4_CODE     = 8'he8;
  localparam logic [7:0] CTRL_RESET    = 8'h00;
  localparam logic [7:0] SETSEL_RESET  = 8'h00;
  localparam logic [7:0] VERSION_ID    = 8'h10;
  // line status bits
  localparam int LS_LAST_BYTE  = 7;
  localparam int LS_LEN_EXCEED = 4;
  localparam int LS_PHYSICAL_SYMBOL_ERROR    = 3;
  localparam int LS_CRC_ERR    = 2;
  localparam int LS_OVERRUN    = 1;
  localparam int LS_RX_READY   = 0;
  // user status bits
  localparam int US_FLOW   = 7;
  localparam int US_UNDRUN = 6;
  localparam int US_BUSY   = 5;
  localparam int US_LOST   = 4;
  localparam int US_FEND   = 3;
  localparam int US_FIFOFE = 1;
  localparam int US_TOUT   = 0;
  // control bits
  localparam int AC1_BR_OUT  = 7;
  localparam int AC1_LOOPOUT = 5;
  localparam int AC1_SWAP    = 4;
  localparam int AC1_ADVSEL  = 0;
  localparam int AC2_FBDIS   = 7;
  localparam int HC_EN_DMA   = 2;
  localparam int HC_MODE_LO  = 5;
  localparam int IRS_CLR_LO  = 2;
  localparam int IRS_CLR_HI  = 3;
  // mode codes
  localparam logic [2:0] MODE_MIR_LO  = 3'h1;
  localparam logic [2:0] MODE_MIR_HI  = 3'h4;
  localparam logic [2:0] MODE_FIR     = 3'h5;
  localparam logic [2:0] MODE_REMOTE  = 3'h6;
endpackage

// *** design/auirs_top.sv ***
// module: advanced uart ir status, control and register sets over ahb-lite
//
// Register access over AHB-Lite was chosen for this implementation.
`timescale 1ns/1ps
module auirs_top
  import auirs_pkg::*;
(
  input  wire logic        REF_CLK_IN,
  input  wire logic        RESET_IN,
  input  wire logic        HSEL_IN,
  input  wire logic [31:0] HADDR_IN,
  input  wire logic [1:0]  HTRANS_IN,
  input  wire logic        HWRITE_IN,
  input  wire logic [2:0]  HSIZE_IN,
  input  wire logic [31:0] HWDATA_IN,
  input  wire logic        HREADY_IN,
  output logic      [31:0] HRDATA_OUT,
  output logic             HREADYOUT_OUT,
  output logic             HRESP_OUT,
  input  wire logic        RX_LAST_BYTE_IN,
  input  wire logic        RX_LEN_EXCEED_IN,
  input  wire logic        RX_BAD_SYMBOL_IN,
  input  wire logic        RX_CRC_BAD_IN,
  input  wire logic        FLOW_EVENT_IN,
  input  wire logic        TX_EMPTY_IN,
  input  wire logic        TERMINAL_COUNT_IN,
  input  wire logic        RX_ACTIVE_IN,
  input  wire logic        FRAME_END_LOST_IN,
  input  wire logic        REMOTE_PULSE_IN,
  input  wire logic        FRAME_END_IN_FIFO_IN,
  input  wire logic        RX_TIMEOUT_IN,
  input  wire logic        RX_DMA_CFG_IN,
  input  wire logic        TX_DMA_CFG_IN,
  input  wire logic [5:0]  TX_FIFO_LEVEL_IN,
  input  wire logic [5:0]  RX_FIFO_LEVEL_IN,
  output logic             RX_WRITE_BLOCK_OUT,
  output logic             RX_DECODER_ABORT_OUT,
  output logic             RX_FRAME_END_OUT,
  output logic             SINGLE_DMA_OUT,
  output logic             DMA_SERVES_TX_OUT,
  output logic             TX_FRAME_END_OUT,
  output logic             ADVANCED_MODE_OUT,
  output logic      [2:0]  IR_MODE_OUT,
  output logic      [15:0] BAUD_DIVISOR_OUT
);
  import auirs_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // pin synchronisers
  localparam int NS = 14;
  logic [NS-1:0] raw_in;
  logic [NS-1:0] s1_reg;
  logic [NS-1:0] s2_reg;
  assign raw_in = {RX_LAST_BYTE_IN, RX_LEN_EXCEED_IN, RX_BAD_SYMBOL_IN, RX_CRC_BAD_IN,
                   FLOW_EVENT_IN, TX_EMPTY_IN, TERMINAL_COUNT_IN, RX_ACTIVE_IN,
                   FRAME_END_LOST_IN, REMOTE_PULSE_IN, FRAME_END_IN_FIFO_IN, RX_TIMEOUT_IN,
                   RX_DMA_CFG_IN, TX_DMA_CFG_IN};
  always_ff @(posedge REF_CLK_IN)
  begin
    if (RESET_IN)
    begin
      s1_reg <= '0;
      s2_reg <= '0;
    end
    else
    begin
      s1_reg <= raw_in;
      s2_reg <= s1_reg;
    end
  end
  logic [5:0] txl_s1_reg;
  logic [5:0] txl_reg;
  logic [5:0] rxl_s1_reg;
  logic [5:0] rxl_reg;
  always_ff @(posedge REF_CLK_IN)
  begin
    if (RESET_IN)
    begin
      txl_s1_reg <= '0;
      txl_reg    <= '0;
      rxl_s1_reg <= '0;
      rxl_reg    <= '0;
    end
    else
    begin
      txl_s1_reg <= TX_FIFO_LEVEL_IN;
      txl_reg    <= txl_s1_reg;
      rxl_s1_reg <= RX_FIFO_LEVEL_IN;
      rxl_reg    <= rxl_s1_reg;
    end
  end
  wire ev_last  = s2_reg[13];
  wire ev_lenx  = s2_reg[12];
  wire ev_sym   = s2_reg[11];
  wire ev_crc   = s2_reg[10];
  wire ev_flow  = s2_reg[9];
  wire tx_empty = s2_reg[8];
  wire tc_seen  = s2_reg[7];
  wire rx_act   = s2_reg[6];
  wire ev_lost  = s2_reg[5];
  wire ev_pulse = s2_reg[4];
  wire fe_fifo  = s2_reg[3];
  wire ev_tout  = s2_reg[2];
  wire rx_dma   = s2_reg[1];
  wire tx_dma   = s2_reg[0];

  ////////////////////////////////////////////////////////////////////////
  // ahb-lite address phase capture
  logic       ph_wr_reg;
  logic       ph_rd_reg;
  logic [3:0] ph_ofs_reg;
  wire        take   = HSEL_IN & HREADY_IN & HTRANS_IN[1];
  wire  [3:0] a_ofs  = {1'b0, HADDR_IN[4:2]};
  wire        a_hi   = |HADDR_IN[31:5];
  wire        a_rd   = take & ~HWRITE_IN;
  wire  [3:0] a_sel  = a_hi ? 4'hf : a_ofs;
  always_ff @(posedge REF_CLK_IN)
  begin
    if (RESET_IN)
    begin
      ph_wr_reg  <= 1'b0;
      ph_rd_reg  <= 1'b0;
      ph_ofs_reg <= 4'h0;
    end
    else
    begin
      ph_wr_reg  <= take & HWRITE_IN & ~a_hi;
      ph_rd_reg  <= take & ~HWRITE_IN;
      ph_ofs_reg <= a_hi ? 4'hf : a_ofs;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // register state
  logic [7:0] setsel_reg;
  logic [7:0] div_lo_reg;
  logic [7:0] div_hi_reg;
  logic [7:0] adiv_lo_reg;
  logic [7:0] adiv_hi_reg;
  logic [7:0] fifo_ctl_reg;
  logic [7:0] line_ctl_reg;
  logic [7:0] hs_ctl_reg;
  logic [7:0] adc1_reg;
  logic [7:0] adc2_reg;
  logic [7:0] irsel_reg;
  logic [7:0] lstat_reg;
  logic [7:0] ustat_reg;
  logic [7:0] wd;
  assign wd = HWDATA_IN[7:0];

  wire in_set2  = setsel_reg == SET2_CODE;
  wire in_set3  = setsel_reg == SET3_CODE;
  wire in_set4  = setsel_reg == SET4_CODE;
  wire in_set1  = setsel_reg[7] & ~in_set2 & ~in_set3 & ~in_set4 & (setsel_reg[7:5] != 3'h7);
  wire in_set0  = ~setsel_reg[7];
  wire legacy_s = in_set0 | in_set1;
  wire adv_on   = adc1_reg[AC1_ADVSEL];
  wire [2:0] mode = hs_ctl_reg[7:5];
  wire hs_mode  = adv_on & (mode == MODE_MIR_LO | mode == MODE_MIR_HI | mode == MODE_FIR);
  wire rem_mode = adv_on & (mode == MODE_REMOTE);

  wire wr_at    = ph_wr_reg;
  wire rd_at    = ph_rd_reg;
  wire w_ssr    = wr_at & (ph_ofs_reg == OFS_LINE_SET);
  wire w_lcr    = wr_at & (ph_ofs_reg == OFS_LINE_SET) & legacy_s;
  wire w_dlo    = wr_at & in_set1 & (ph_ofs_reg == OFS_DIV_LO);
  wire w_dhi    = wr_at & in_set1 & (ph_ofs_reg == OFS_DIV_HI);
  wire w_adlo   = wr_at & in_set2 & (ph_ofs_reg == OFS_DIV_LO);
  wire w_adhi   = wr_at & in_set2 & (ph_ofs_reg == OFS_DIV_HI);
  wire div_acc  = (wr_at | rd_at) & in_set1 & (ph_ofs_reg <= OFS_DIV_HI);
  wire fb_adv   = div_acc & adv_on;
  wire fb_leg   = div_acc & ~adv_on & ~adc2_reg[AC2_FBDIS];
  wire w_fifo   = wr_at & legacy_s & (ph_ofs_reg == OFS_IRQ_FIFO);
  wire w_hsc    = wr_at & legacy_s & (ph_ofs_reg == OFS_HS_CTRL);
  wire w_ac1    = wr_at & in_set2 & (ph_ofs_reg == OFS_IRQ_FIFO);
  wire w_ac2    = wr_at & in_set2 & (ph_ofs_reg == OFS_ADV_CTRL2);
  wire w_irs    = wr_at & in_set4 & (ph_ofs_reg == OFS_IR_SELECT);
  wire w_ustat  = wr_at & legacy_s & (ph_ofs_reg == OFS_USER_STAT);
  wire r_ustat  = a_rd & legacy_s & (a_sel == OFS_USER_STAT);
  wire r_lstat  = a_rd & legacy_s & (a_sel == OFS_LINE_STAT);

  ////////////////////////////////////////////////////////////////////////
  // set select, line control and fifo control
  always_ff @(posedge REF_CLK_IN)
  begin
    if (RESET_IN)
    begin
      setsel_reg   <= SETSEL_RESET;
      fifo_ctl_reg <= CTRL_RESET;
      line_ctl_reg <= CTRL_RESET;
    end
    else
    begin
      if (w_ssr)
        setsel_reg <= wd;
      if (w_lcr)
        line_ctl_reg <= wd;
      if (w_fifo)
        fifo_ctl_reg <= wd;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // legacy and advanced divisor latches
  always_ff @(posedge REF_CLK_IN)
  begin
    if (RESET_IN)
    begin
      div_lo_reg  <= CTRL_RESET;
      div_hi_reg  <= CTRL_RESET;
      adiv_lo_reg <= CTRL_RESET;
      adiv_hi_reg <= CTRL_RESET;
    end
    else
    begin
      if (w_dlo)
        div_lo_reg <= wd;
      if (w_dhi)
        div_hi_reg <= wd;
      if (w_adlo)
        adiv_lo_reg <= wd;
      if (w_adhi)
        adiv_hi_reg <= wd;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // control registers with fallback clears
  always_ff @(posedge REF_CLK_IN)
  begin
    if (RESET_IN)
    begin
      hs_ctl_reg  <= CTRL_RESET;
      adc1_reg    <= CTRL_RESET;
      adc2_reg    <= CTRL_RESET;
      irsel_reg   <= CTRL_RESET;
    end
    else
    begin
      if (w_ac2)
        adc2_reg <= wd & 8'hbf;
      if (fb_adv)
        hs_ctl_reg <= hs_ctl_reg & 8'h1f;
      else if (w_hsc)
        hs_ctl_reg <= wd;
      if (fb_adv)
        adc1_reg <= adc1_reg & ~8'ha1;
      else if (fb_leg)
        adc1_reg <= adc1_reg & ~8'ha0;
      else if (w_ac1)
        adc1_reg <= wd & 8'hbf;
      if (fb_adv)
        irsel_reg <= irsel_reg & ~8'h0c;
      else if (w_irs)
        irsel_reg <= wd;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // status flags, hardware set wins over software clear
  logic [7:0] lstat_next;
  logic [7:0] ustat_next;
  logic       fend_cmd_reg;
  wire fend_w   = w_ustat & wd[US_FEND];
  wire und_ev   = hs_mode & tx_empty & ~fend_cmd_reg & ~tc_seen;
  always_comb
  begin
    lstat_next = lstat_reg;
    if (r_lstat)
      lstat_next = 8'h00;
    lstat_next[LS_LAST_BYTE]  = hs_mode & ev_last;
    if (hs_mode & ev_lenx)
      lstat_next[LS_LEN_EXCEED] = 1'b1;
    if (hs_mode & ev_sym)
      lstat_next[LS_PHYSICAL_SYMBOL_ERROR] = 1'b1;
    if (hs_mode & ev_crc)
      lstat_next[LS_CRC_ERR] = 1'b1;
    lstat_next[6:5] = 2'b00;
    lstat_next[1:0] = 2'b00;
    ustat_next = ustat_reg;
    if (r_ustat)
    begin
      ustat_next[US_FLOW] = 1'b0;
      ustat_next[US_LOST] = 1'b0;
    end
    if (w_ustat & wd[US_UNDRUN])
      ustat_next[US_UNDRUN] = 1'b0;
    if (und_ev)
      ustat_next[US_UNDRUN] = 1'b1;
    if (hs_mode & ev_flow)
      ustat_next[US_FLOW] = 1'b1;
    if ((hs_mode & ev_lost) | (rem_mode & ev_pulse))
      ustat_next[US_LOST] = 1'b1;
    ustat_next[US_BUSY]   = (hs_mode | rem_mode) & rx_act;
    ustat_next[US_FEND]   = fend_cmd_reg;
    ustat_next[2]         = 1'b0;
    ustat_next[US_FIFOFE] = hs_mode & fe_fifo;
    ustat_next[US_TOUT]   = (hs_mode | rem_mode) & ev_tout;
  end
  always_ff @(posedge REF_CLK_IN)
  begin
    if (RESET_IN)
    begin
      lstat_reg    <= CTRL_RESET;
      ustat_reg    <= CTRL_RESET;
      fend_cmd_reg <= 1'b0;
    end
    else
    begin
      lstat_reg    <= lstat_next;
      ustat_reg    <= ustat_next;
      fend_cmd_reg <= fend_w ? 1'b1 : (tx_empty ? 1'b0 : fend_cmd_reg);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // read mux, decoded in the address phase so data stands in the data phase
  wire [7:0] rv_div_lo   = in_set2 ? adiv_lo_reg : (in_set1 ? div_lo_reg : (in_set3 ? VERSION_ID : 8'h00));
  wire [7:0] rv_div_hi   = in_set2 ? adiv_hi_reg : (in_set1 ? div_hi_reg : (in_set3 ? line_ctl_reg : 8'h00));
  wire [7:0] rv_irq_fifo = in_set2 ? adc1_reg : (in_set3 ? fifo_ctl_reg : (in_set4 ? irsel_reg : fifo_ctl_reg));
  wire [7:0] rv_line_set = legacy_s ? line_ctl_reg : setsel_reg;
  wire [7:0] rv_hs_ctrl  = in_set2 ? adc2_reg : (legacy_s ? hs_ctl_reg : 8'h00);
  wire [7:0] rv_lstat    = legacy_s ? lstat_reg : 8'h00;
  wire [7:0] rv_hs_stat  = in_set2 ? {2'b00, txl_reg} : 8'h00;
  wire [7:0] rv_ustat    = in_set2 ? {2'b00, rxl_reg} : (legacy_s ? ustat_reg : 8'h00);
  logic [7:0] rd_sel;
  always_comb
  begin
    rd_sel = 8'h00;
    case (a_sel)
      OFS_DIV_LO    : rd_sel = rv_div_lo;
      OFS_DIV_HI    : rd_sel = rv_div_hi;
      OFS_IRQ_FIFO  : rd_sel = rv_irq_fifo;
      OFS_LINE_SET  : rd_sel = rv_line_set;
      OFS_HS_CTRL   : rd_sel = rv_hs_ctrl;
      OFS_LINE_STAT : rd_sel = rv_lstat;
      OFS_HS_STAT   : rd_sel = rv_hs_stat;
      OFS_USER_STAT : rd_sel = rv_ustat;
      default       : rd_sel = 8'h00;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // bus output flops
  always_ff @(posedge REF_CLK_IN)
  begin
    if (RESET_IN)
    begin
      HRDATA_OUT           <= 32'h0000_0000;
      HREADYOUT_OUT        <= 1'b1;
      HRESP_OUT            <= 1'b0;
    end
    else
    begin
      HRDATA_OUT           <= a_rd ? {24'h000000, rd_sel} : HRDATA_OUT;
      HREADYOUT_OUT        <= 1'b1;
      HRESP_OUT            <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // line side output flops
  always_ff @(posedge REF_CLK_IN)
  begin
    if (RESET_IN)
    begin
      RX_WRITE_BLOCK_OUT   <= 1'b0;
      RX_DECODER_ABORT_OUT <= 1'b0;
      RX_FRAME_END_OUT     <= 1'b0;
      SINGLE_DMA_OUT       <= 1'b0;
      DMA_SERVES_TX_OUT    <= 1'b0;
      TX_FRAME_END_OUT     <= 1'b0;
      ADVANCED_MODE_OUT    <= 1'b0;
      IR_MODE_OUT          <= 3'h0;
      BAUD_DIVISOR_OUT     <= 16'h0000;
    end
    else
    begin
      RX_WRITE_BLOCK_OUT   <= lstat_next[LS_LEN_EXCEED];
      RX_DECODER_ABORT_OUT <= hs_mode & ev_sym;
      RX_FRAME_END_OUT     <= hs_mode & ev_sym;
      SINGLE_DMA_OUT       <= hs_ctl_reg[HC_EN_DMA] & rx_dma & ~tx_dma;
      DMA_SERVES_TX_OUT    <= adc1_reg[AC1_SWAP];
      TX_FRAME_END_OUT     <= fend_cmd_reg;
      ADVANCED_MODE_OUT    <= adv_on;
      IR_MODE_OUT          <= mode;
      BAUD_DIVISOR_OUT     <= adv_on ? {adiv_hi_reg, adiv_lo_reg} : {div_hi_reg, div_lo_reg};
    end
  end
endmodule

// *** verification/auirs_chk.sv ***
// checker: port-level assertions of the advanced uart status block
`timescale 1ns/1ps
module auirs_chk
  import auirs_pkg::*;
(
  input wire logic        REF_CLK_IN,
  input wire logic        RESET_IN,
  input wire logic        HSEL_IN,
  input wire logic [1:0]  HTRANS_IN,
  input wire logic        HWRITE_IN,
  input wire logic        HREADY_IN,
  input wire logic [31:0] HRDATA_OUT,
  input wire logic        HREADYOUT_OUT,
  input wire logic        HRESP_OUT,
  input wire logic        RX_LEN_EXCEED_IN,
  input wire logic        RX_DMA_CFG_IN,
  input wire logic        RX_WRITE_BLOCK_OUT,
  input wire logic        RX_DECODER_ABORT_OUT,
  input wire logic        RX_FRAME_END_OUT,
  input wire logic        SINGLE_DMA_OUT,
  input wire logic        DMA_SERVES_TX_OUT,
  input wire logic        TX_FRAME_END_OUT,
  input wire logic        ADVANCED_MODE_OUT,
  input wire logic [2:0]  IR_MODE_OUT
);
  wire wr_a   = HSEL_IN && HREADY_IN && HTRANS_IN[1] && HWRITE_IN;
  wire mirfir = (IR_MODE_OUT == MODE_MIR_LO) || (IR_MODE_OUT == MODE_MIR_HI) || (IR_MODE_OUT == MODE_FIR);
  default clocking cb @(posedge REF_CLK_IN);
  endclocking
  default disable iff (RESET_IN);
  ////////////////////////////////////////////////////////////////////////
  sequence s_ok;
    HREADYOUT_OUT && !HRESP_OUT;
  endsequence
  sequence s_len_cause;
    $past(RX_LEN_EXCEED_IN, 2) || $past(RX_LEN_EXCEED_IN, 3) || $past(RX_LEN_EXCEED_IN, 4);
  endsequence
  sequence s_wr_cause;
    $past(wr_a, 2) || $past(wr_a, 3);
  endsequence
  property p_bus_ok;
    1'b1 |-> s_ok;
  endproperty
  property p_hi_zero;
    HRDATA_OUT[31:8] == 24'h0;
  endproperty
  property p_len_block;
    $rose(RX_WRITE_BLOCK_OUT) |-> s_len_cause;
  endproperty
  property p_abort;
    RX_DECODER_ABORT_OUT |-> RX_FRAME_END_OUT && ADVANCED_MODE_OUT && mirfir;
  endproperty
  property p_single;
    $rose(SINGLE_DMA_OUT) |-> $past(RX_DMA_CFG_IN, 2) || $past(RX_DMA_CFG_IN, 3) || $past(RX_DMA_CFG_IN, 4);
  endproperty
  property p_swap;
    $changed(DMA_SERVES_TX_OUT) |-> s_wr_cause;
  endproperty
  property p_fend;
    $rose(TX_FRAME_END_OUT) |-> s_wr_cause;
  endproperty
  property p_fall;
    $fell(ADVANCED_MODE_OUT) |-> IR_MODE_OUT == 3'h0;
  endproperty
  a_bus_ok: assert property (p_bus_ok) else $error("bus not ready or not okay");
  a_hi_zero: assert property (p_hi_zero) else $error("upper read data not zero");
  a_len_block: assert property (p_len_block) else $error("rx block without length event");
  a_abort: assert property (p_abort) else $error("abort without frame end or mode");
  a_single: assert property (p_single) else $error("single dma without rx config");
  a_swap: assert property (p_swap) else $error("swap changed without write");
  a_fend: assert property (p_fend) else $error("frame end command without write");
  a_fall: assert property (p_fall) else $error("fallback left mode bits");
endmodule
bind auirs_top auirs_chk i_auirs_chk
(
  .REF_CLK_IN(REF_CLK_IN), .RESET_IN(RESET_IN), .HSEL_IN(HSEL_IN), .HTRANS_IN(HTRANS_IN),
  .HWRITE_IN(HWRITE_IN), .HREADY_IN(HREADY_IN), .HRDATA_OUT(HRDATA_OUT), .HREADYOUT_OUT(HREADYOUT_OUT),
  .HRESP_OUT(HRESP_OUT), .RX_LEN_EXCEED_IN(RX_LEN_EXCEED_IN), .RX_DMA_CFG_IN(RX_DMA_CFG_IN),
  .RX_WRITE_BLOCK_OUT(RX_WRITE_BLOCK_OUT), .RX_DECODER_ABORT_OUT(RX_DECODER_ABORT_OUT),
  .RX_FRAME_END_OUT(RX_FRAME_END_OUT), .SINGLE_DMA_OUT(SINGLE_DMA_OUT), .DMA_SERVES_TX_OUT(DMA_SERVES_TX_OUT),
  .TX_FRAME_END_OUT(TX_FRAME_END_OUT), .ADVANCED_MODE_OUT(ADVANCED_MODE_OUT), .IR_MODE_OUT(IR_MODE_OUT)
);

// *** verification/auirs_line_peer.sv ***
// line-side peer: presents receive, transmit and dma events and fifo levels
`timescale 1ns/1ps
module auirs_line_peer
(
  input  wire logic        clk_in,
  input  wire logic [13:0] ev_in,
  input  wire logic [5:0]  tx_lvl_in,
  input  wire logic [5:0]  rx_lvl_in,
  output logic      [13:0] pin_out = 14'h0,
  output logic      [5:0]  tx_lvl_out = 6'h0,
  output logic      [5:0]  rx_lvl_out = 6'h0
);
  // pins move only just after a clock edge
  always @(posedge clk_in)
  begin
    pin_out    <= ev_in;
    tx_lvl_out <= tx_lvl_in;
    rx_lvl_out <= rx_lvl_in;
  end
endmodule

// *** verification/testbench.sv ***
// testbench: register, status event, dma and fallback scenarios
`timescale 1ns/1ps
module testbench;
  import auirs_pkg::*;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        hsel = 1'b0;
  logic        hwrite = 1'b0;
  logic [1:0]  htrans = 2'h0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] rdv;
  logic [13:0] ev = 14'h0;
  logic [5:0]  txl = 6'h0;
  logic [5:0]  rxl = 6'h0;
  logic [7:0]  d0;
  logic [7:0]  d1;
  logic [7:0]  a1;
  logic [2:0]  mt [3] = '{MODE_MIR_LO, MODE_MIR_HI, MODE_FIR};
  wire  [13:0] pin;
  wire  [5:0]  ptx;
  wire  [5:0]  prx;
  wire  [31:0] hrdata;
  wire  [15:0] baud;
  wire  [2:0]  mode;
  wire         hready, hresp, wblk, abrt, rfe, sdma, stx, tfe, adv;
  int          n_mismatch = 0;
  int          samples_checked = 0;
  always #12.5 clk = ~clk;
  auirs_top i_auirs_top
  (
    .REF_CLK_IN(clk), .RESET_IN(rst), .HSEL_IN(hsel), .HADDR_IN(haddr), .HTRANS_IN(htrans), .HWRITE_IN(hwrite),
    .HSIZE_IN(3'h2), .HWDATA_IN(hwdata), .HREADY_IN(hready), .HRDATA_OUT(hrdata), .HREADYOUT_OUT(hready),
    .HRESP_OUT(hresp), .RX_LAST_BYTE_IN(pin[0]), .RX_LEN_EXCEED_IN(pin[1]), .RX_BAD_SYMBOL_IN(pin[2]),
    .RX_CRC_BAD_IN(pin[3]), .FLOW_EVENT_IN(pin[4]), .TX_EMPTY_IN(pin[5]), .TERMINAL_COUNT_IN(pin[6]),
    .RX_ACTIVE_IN(pin[7]), .FRAME_END_LOST_IN(pin[8]), .REMOTE_PULSE_IN(pin[9]), .FRAME_END_IN_FIFO_IN(pin[10]),
    .RX_TIMEOUT_IN(pin[11]), .RX_DMA_CFG_IN(pin[12]), .TX_DMA_CFG_IN(pin[13]), .TX_FIFO_LEVEL_IN(ptx),
    .RX_FIFO_LEVEL_IN(prx), .RX_WRITE_BLOCK_OUT(wblk), .RX_DECODER_ABORT_OUT(abrt), .RX_FRAME_END_OUT(rfe),
    .SINGLE_DMA_OUT(sdma), .DMA_SERVES_TX_OUT(stx), .TX_FRAME_END_OUT(tfe), .ADVANCED_MODE_OUT(adv),
    .IR_MODE_OUT(mode), .BAUD_DIVISOR_OUT(baud)
  );
  auirs_line_peer i_auirs_line_peer
  (
    .clk_in(clk), .ev_in(ev), .tx_lvl_in(txl), .rx_lvl_in(rxl), .pin_out(pin), .tx_lvl_out(ptx), .rx_lvl_out(prx)
  );
  ////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] us_exp(input logic [7:0] b);
    return {24'h0, b & 8'hfb};
  endfunction
  function automatic logic [31:0] fb_exp(input logic [7:0] a, input logic advm, input logic dis);
    return {24'h0, advm ? (a & ~8'ha1) : (dis ? a : (a & ~8'ha0))};
  endfunction
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic tk(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic hwait;
    int k;
    k = 0;
    do
    begin
      @(posedge clk);
      k++;
    end
    while (hready !== 1'b1 && k < 40);
    if (k >= 40)
    begin
      n_mismatch++;
      wrap_up();
    end
  endtask
  task automatic bus(input logic w, input logic [31:0] a, input logic [7:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= a;
    hwait();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= {24'h0, d};
    hwait();
    rdv = hrdata;
  endtask
  task automatic wr(input logic [3:0] o, input logic [7:0] d);
    bus(1'b1, {26'h0, o, 2'b00}, d);
  endtask
  task automatic rd(input logic [3:0] o, input logic [31:0] exp);
    bus(1'b0, {26'h0, o, 2'b00}, 8'h0);
    chk(rdv, exp);
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial
  begin
    void'($urandom(87));
    tk(4);
    rst <= 1'b0;
    tk(1);
    rd(4'h5, 32'h0);
    rd(4'h7, 32'h0);
    chk({31'h0, hresp}, 32'h0);
    $display("test reset done");
    d0 = 8'($urandom);
    d1 = 8'($urandom);
    txl <= 6'($urandom);
    rxl <= 6'($urandom);
    wr(4'h3, SET2_CODE);
    rd(4'h3, 32'h0000_00e0);
    wr(4'h2, 8'h01);
    wr(4'h0, d0);
    wr(4'h1, d1);
    rd(4'h0, {24'h0, d0});
    rd(4'h1, {24'h0, d1});
    rd(4'h5, 32'h0);
    rd(4'h6, {26'h0, txl});
    rd(4'h7, {26'h0, rxl});
    wr(4'h3, SET3_CODE);
    rd(4'h3, 32'h0000_00e4);
    wr(4'h3, 8'h00);
    bus(1'b1, 32'h0000_0100, 8'hff);
    bus(1'b0, 32'h0000_0100, 8'h0);
    chk(rdv, 32'h0);
    $display("test register map done");
    for (int i = 0; i < 3; i++)
    begin
      wr(4'h4, {mt[i], 5'h04});
      tk(2);
      chk({28'h0, adv, mode}, {29'h1, mt[i]});
      ev <= 14'h0004;
      tk(6);
      chk({30'h0, abrt, rfe}, 32'h3);
      ev <= 14'h0;
      tk(6);
      rd(4'h5, 32'h08);
      rd(4'h5, 32'h0);
    end
    ev <= 14'h000b;
    tk(6);
    chk({31'h0, wblk}, 32'h1);
    ev <= 14'h0;
    tk(6);
    rd(4'h5, 32'h04 | 32'h10);
    ev <= 14'h0001;
    tk(6);
    rd(4'h5, 32'h80);
    ev <= 14'h0d90;
    tk(6);
    ev <= 14'h0c80;
    tk(6);
    rd(4'h7, us_exp(8'hb3));
    rd(4'h7, us_exp(8'h23));
    $display("test status done");
    ev <= 14'h0060;
    tk(6);
    ev <= 14'h0;
    tk(6);
    rd(4'h7, 32'h0);
    wr(4'h7, 8'h0c);
    tk(2);
    rd(4'h7, us_exp(8'h0c));
    ev <= 14'h0020;
    tk(1);
    ev <= 14'h0;
    tk(6);
    chk({31'h0, tfe}, 32'h0);
    rd(4'h7, 32'h0);
    ev <= 14'h0020;
    tk(6);
    ev <= 14'h0;
    tk(6);
    rd(4'h7, 32'h40);
    wr(4'h7, 8'h40);
    rd(4'h7, 32'h0);
    $display("test underrun done");
    for (int j = 0; j < 4; j++)
    begin
      ev <= {j[1], j[0], 12'h0};
      tk(6);
      chk({31'h0, sdma}, {31'h0, j[0] & ~j[1]});
    end
    ev <= 14'h0;
    for (int f = 0; f < 3; f++)
    begin
      a1 = (f == 0) ? 8'hb1 : 8'hb0;
      wr(4'h3, SET2_CODE);
      wr(4'h4, (f == 2) ? 8'h80 : 8'h00);
      wr(4'h2, a1);
      tk(2);
      chk({31'h0, stx}, 32'h1);
      wr(4'h3, 8'h80);
      wr(4'h0, 8'h55);
      rd(4'h6, 32'h0);
      wr(4'h3, SET2_CODE);
      rd(4'h2, fb_exp(a1, f == 0, f == 2));
      chk({28'h0, adv, mode}, 32'h0);
    end
    $display("test dma and fallback done");
    wr(4'h2, 8'h01);
    wr(4'h3, 8'h00);
    wr(4'h4, {MODE_REMOTE, 5'h00});
    ev <= 14'h0280;
    tk(6);
    ev <= 14'h0080;
    tk(6);
    rd(4'h7, us_exp(8'h30));
    rd(4'h7, us_exp(8'h20));
    ev <= 14'h0;
    $display("test remote done");
    wrap_up();
  end
endmodule
